// ==== core/spm_serial_merge.sv ====
// Dual-port serial front end: merged receive, mirrored transmit, AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "spm_cfg.svh"

// Contract
// R1 - AND both receive inputs into one path
// R2 - Space on either input gives zero
// R3 - Loop disable forces loop input to mark
// R4 - Loop disable never touches transmit outputs
// R5 - Each transmit bit drives both outputs
// R6 - One frame setting serves both ports
// R7 - Senders never transmit on both inputs together
// R8 - Idle loop sender holds mark
// R9 - Four frames: 7/8 data, parity optional
// R10 - Parity enable plus even/odd select
// R11 - Baud rates 300 through 19200
// R12 - Unit address 0..99, ASCII characters
// R13 - Transmitter and receiver run independently
// R14 - Falling start, centre sample, framing error
// R15 - Parity mismatch raises parity error
module spm_serial_merge (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rs232_rx,
    input  wire logic        loop_rx,
    output logic             rs232_tx,
    output logic             loop_tx
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] rs_sync_reg;
    logic [1:0] lp_sync_reg;
    logic       rx_merged;

    // Idle line is mark, so synchronisers reset high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rs_sync_reg <= 2'h3;
            lp_sync_reg <= 2'h3;
        end else begin
            rs_sync_reg <= {rs_sync_reg[0], rs232_rx};
            lp_sync_reg <= {lp_sync_reg[0], loop_rx};
        end
    end

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    logic [31:0]      ctrl_reg;
    logic [6:0]       unit_addr_reg;
    logic [7:0]       tx_hold_reg;
    logic             tx_pend_reg;
    logic [7:0]       rx_data_reg;
    spm_pkg::spm_rxst_t rxst_reg;
    logic             wr_pend_reg;
    logic [11:0]      wr_addr_reg;
    spm_pkg::spm_cfg_t cfg;
    logic             loop_eff;
    logic             addr_phase;
    logic             rd_now;
    logic [31:0]      rd_mux;
    logic             wr_ctrl;
    logic             wr_tx;
    logic             wr_addr;
    logic             rd_rx;
    logic             tx_busy;

    assign cfg = spm_pkg::spm_cfg_t'({ctrl_reg[`SPM_CTRL_LOOP_DIS],
                                      ctrl_reg[`SPM_CTRL_SEVEN],
                                      ctrl_reg[`SPM_CTRL_PAR_ODD],
                                      ctrl_reg[`SPM_CTRL_PAR_EN],
                                      ctrl_reg[`SPM_CTRL_BAUD_MSB:`SPM_CTRL_BAUD_LSB]});

    // Disable pulls the loop side to mark; only receive sees it
    assign loop_eff  = lp_sync_reg[1] | cfg.loop_dis;         // [R3] [R4]
    // Space on either side wins; overlapping senders would garble this
    assign rx_merged = rs_sync_reg[1] & loop_eff;             // [R1] [R2] [R7] [R8]

    // Address phase decode
    assign addr_phase = hsel & hready & htrans[1];
    assign rd_now     = addr_phase & ~hwrite;
    assign wr_ctrl    = wr_pend_reg & (wr_addr_reg == `SPM_OFF_CTRL);
    assign wr_tx      = wr_pend_reg & (wr_addr_reg == `SPM_OFF_TXDATA);
    assign wr_addr    = wr_pend_reg & (wr_addr_reg == `SPM_OFF_ADDR);
    assign rd_rx      = rd_now & (haddr == `SPM_OFF_RXDATA);

    // Read select; unmapped addresses read zero
    assign rd_mux = (haddr == `SPM_OFF_CTRL)   ? {25'h0, ctrl_reg[6:0]} :
                    (haddr == `SPM_OFF_STATUS) ? {27'h0, tx_pend_reg | tx_busy,
                                                  rxst_reg} :
                    (haddr == `SPM_OFF_TXDATA) ? {24'h0, tx_hold_reg} :
                    (haddr == `SPM_OFF_RXDATA) ? {24'h0, rx_data_reg} :
                    (haddr == `SPM_OFF_ADDR)   ? {25'h0, unit_addr_reg} : 32'h0;

    // Zero-wait slave; writes land from the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            wr_addr_reg <= haddr;
            hrdata      <= rd_now ? rd_mux : 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    // Settings shared by both ports; address values above 99 are clipped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg      <= `SPM_CTRL_RESET;
            unit_addr_reg <= `SPM_ADDR_RESET;
        end else begin
            if (wr_ctrl) ctrl_reg <= {25'h0, hwdata[6:0]};            // [R6] [R9] [R10]
            if (wr_addr) unit_addr_reg <= (hwdata[6:0] > `SPM_ADDR_MAX) ?
                                          `SPM_ADDR_MAX : hwdata[6:0]; // [R12]
        end
    end

    // ------------------------------------------------------------------------
    // Baud tick, 16x oversample
    // ------------------------------------------------------------------------
    // Thirteen bits: the slowest rate's divisor does not fit in twelve
    logic [12:0] div_reg;
    logic [12:0] div_sel;
    logic        tick;

    assign div_sel = (cfg.baud == 3'h0) ? `SPM_DIV_300  :
                     (cfg.baud == 3'h1) ? `SPM_DIV_600  :
                     (cfg.baud == 3'h2) ? `SPM_DIV_1200 :
                     (cfg.baud == 3'h3) ? `SPM_DIV_2400 :
                     (cfg.baud == 3'h4) ? `SPM_DIV_4800 :
                     (cfg.baud == 3'h5) ? `SPM_DIV_9600 : `SPM_DIV_19200; // [R11]
    assign tick    = (div_reg >= div_sel);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) div_reg <= 13'h0000;
        else          div_reg <= tick ? 13'h0000 : div_reg + 13'h0001;
    end

    // ------------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------------
    spm_pkg::spm_state_t tx_st_reg;
    logic [3:0]          tx_os_reg;
    logic [2:0]          tx_bit_reg;
    logic [7:0]          tx_sh_reg;
    logic                tx_par_reg;
    logic                tx_bit_end;
    logic [2:0]          last_bit;
    logic [12:0]         tx_div_reg;
    logic                tx_tick;
    logic                tx_start;
    logic                tx_line;

    assign tx_busy    = (tx_st_reg != spm_pkg::SPM_IDLE);
    // A frame starts in the cycle the engine is idle with a byte waiting
    assign tx_start   = ~tx_busy & tx_pend_reg;
    assign tx_tick    = (tx_div_reg >= div_sel);
    assign tx_bit_end = tx_tick & (tx_os_reg == 4'hf);
    assign last_bit   = cfg.seven ? 3'h6 : 3'h7;

    // Own divider, restarted at each frame: the shared tick would clip the start bit
    always_ff @(posedge hclk or negedge hresetn) begin                 // [R13]
        if (!hresetn) tx_div_reg <= 13'h0000;
        else          tx_div_reg <= (tx_start | tx_tick) ? 13'h0000 : tx_div_reg + 13'h0001;
    end

    // Holding register; a new write while pending overwrites
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_hold_reg <= 8'h00;
            tx_pend_reg <= 1'b0;
        end else if (wr_tx) begin
            tx_hold_reg <= hwdata[7:0];
            tx_pend_reg <= 1'b1;
        end else if (tx_start) begin
            tx_pend_reg <= 1'b0;
        end
    end

    // Frame engine, free of the receiver
    always_ff @(posedge hclk or negedge hresetn) begin                 // [R13]
        if (!hresetn) begin
            tx_st_reg  <= spm_pkg::SPM_IDLE;
            tx_os_reg  <= 4'h0;
            tx_bit_reg <= 3'h0;
            tx_sh_reg  <= 8'h00;
            tx_par_reg <= 1'b0;
            rs232_tx   <= 1'b1;
            loop_tx    <= 1'b1;
        end else begin
            if (tx_tick) tx_os_reg <= tx_os_reg + 4'h1;
            unique case (tx_st_reg)
                spm_pkg::SPM_IDLE: begin
                    if (tx_pend_reg) begin
                        tx_sh_reg  <= tx_hold_reg;
                        tx_par_reg <= cfg.par_odd;                       // [R10]
                        tx_os_reg  <= 4'h0;
                        tx_st_reg  <= spm_pkg::SPM_START;
                    end
                end
                spm_pkg::SPM_START: begin
                    if (tx_bit_end) begin
                        tx_bit_reg <= 3'h0;
                        tx_st_reg  <= spm_pkg::SPM_DATA;
                    end
                end
                spm_pkg::SPM_DATA: begin
                    if (tx_bit_end) begin
                        tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
                        tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
                        tx_bit_reg <= tx_bit_reg + 3'h1;
                        if (tx_bit_reg == last_bit)
                            tx_st_reg <= cfg.par_en ? spm_pkg::SPM_PAR
                                                    : spm_pkg::SPM_STOP;   // [R9]
                    end
                end
                spm_pkg::SPM_PAR: begin
                    if (tx_bit_end) tx_st_reg <= spm_pkg::SPM_STOP;
                end
                spm_pkg::SPM_STOP: begin
                    if (tx_bit_end) tx_st_reg <= spm_pkg::SPM_IDLE;
                end
                default: tx_st_reg <= spm_pkg::SPM_IDLE;
            endcase
            // Same level on both ports, whatever the loop disable says
            rs232_tx <= tx_line;                                          // [R5] [R4]
            loop_tx  <= tx_line;                                          // [R5]
        end
    end

    // Line level per state; idle and stop sit at mark
    assign tx_line = (tx_st_reg == spm_pkg::SPM_START) ? 1'b0 :
                     (tx_st_reg == spm_pkg::SPM_DATA)  ? tx_sh_reg[0] :
                     (tx_st_reg == spm_pkg::SPM_PAR)   ? tx_par_reg : 1'b1;

    // ------------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------------
    spm_pkg::spm_state_t rx_st_reg;
    logic [3:0]          rx_os_reg;
    logic [2:0]          rx_bit_reg;
    logic [7:0]          rx_sh_reg;
    logic                rx_par_reg;
    logic                rx_prev_reg;
    logic                rx_mid;
    logic                rx_done;
    logic                rx_ferr;
    logic                rx_perr;
    logic [7:0]          rx_word;

    // Centre of a bit is eight ticks past its edge
    assign rx_mid  = tick & (rx_os_reg == 4'h7);                       // [R14]
    assign rx_done = (rx_st_reg == spm_pkg::SPM_STOP) & rx_mid;
    assign rx_ferr = ~rx_merged;                                       // [R14]
    assign rx_perr = cfg.par_en & rx_par_reg;                          // [R15]
    assign rx_word = cfg.seven ? {1'b0, rx_sh_reg[7:1]} : rx_sh_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_st_reg   <= spm_pkg::SPM_IDLE;
            rx_os_reg   <= 4'h0;
            rx_bit_reg  <= 3'h0;
            rx_sh_reg   <= 8'h00;
            rx_par_reg  <= 1'b0;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_prev_reg <= rx_merged;
            if (tick) rx_os_reg <= rx_os_reg + 4'h1;
            unique case (rx_st_reg)
                spm_pkg::SPM_IDLE: begin
                    if (rx_prev_reg && !rx_merged) begin                 // [R14]
                        rx_os_reg <= 4'h0;
                        rx_st_reg <= spm_pkg::SPM_START;
                    end
                end
                spm_pkg::SPM_START: begin
                    if (rx_mid) begin
                        rx_bit_reg <= 3'h0;
                        rx_par_reg <= cfg.par_odd;
                        rx_st_reg  <= rx_merged ? spm_pkg::SPM_IDLE
                                                : spm_pkg::SPM_DATA;  // Glitch rejected
                    end
                end
                spm_pkg::SPM_DATA: begin
                    if (rx_mid) begin
                        rx_sh_reg  <= {rx_merged, rx_sh_reg[7:1]};
                        rx_par_reg <= rx_par_reg ^ rx_merged;
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == last_bit)
                            rx_st_reg <= cfg.par_en ? spm_pkg::SPM_PAR
                                                    : spm_pkg::SPM_STOP;
                    end
                end
                spm_pkg::SPM_PAR: begin
                    if (rx_mid) begin
                        rx_par_reg <= rx_par_reg ^ rx_merged;            // [R15]
                        rx_st_reg  <= spm_pkg::SPM_STOP;
                    end
                end
                spm_pkg::SPM_STOP: begin
                    if (rx_mid) rx_st_reg <= spm_pkg::SPM_IDLE;
                end
                default: rx_st_reg <= spm_pkg::SPM_IDLE;
            endcase
        end
    end

    // Received word and flags, rewritten by each character; a data read clears the flags but not the word; a new character wins over a read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_reg <= 8'h00;
            rxst_reg    <= '0;
        end else if (rx_done) begin
            rx_data_reg        <= rx_word;                             // [R12]
            rxst_reg.valid     <= 1'b1;
            rxst_reg.frame_err <= rx_ferr;
            rxst_reg.par_err   <= rx_perr;
            rxst_reg.overrun   <= rxst_reg.valid & ~rd_rx;
        end else if (rd_rx) begin
            rxst_reg <= '0;
        end
    end

endmodule : spm_serial_merge
`default_nettype wire

// ==== core/spm_cfg.svh ====
// Register offsets, field positions, reset values and timing counts of the serial merge block
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SPM_OFF_CTRL     12'h000
`define SPM_OFF_STATUS   12'h004
`define SPM_OFF_TXDATA   12'h008
`define SPM_OFF_RXDATA   12'h00c
`define SPM_OFF_ADDR     12'h010

// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define SPM_CTRL_BAUD_LSB   0
`define SPM_CTRL_BAUD_MSB   2
`define SPM_CTRL_PAR_EN     3
`define SPM_CTRL_PAR_ODD    4
`define SPM_CTRL_SEVEN      5
`define SPM_CTRL_LOOP_DIS   6
`define SPM_CTRL_RESET      32'h0000_0000
`define SPM_ADDR_RESET      7'h00
`define SPM_ADDR_MAX        7'h63

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define SPM_ST_RXVALID   0
`define SPM_ST_FRAMEERR  1
`define SPM_ST_PARERR    2
`define SPM_ST_OVERRUN   3
`define SPM_ST_TXBUSY    4

// ----------------------------------------------------------------------------
// Timing: oversampling at 16x the bit rate, 25 MHz clock
// ----------------------------------------------------------------------------
`define SPM_CLK_HZ       25000000
`define SPM_OVERSAMPLE   16
`define SPM_DIV(baud)    (((`SPM_CLK_HZ) / ((baud) * `SPM_OVERSAMPLE)) - 1)
`define SPM_DIV_300      13'(`SPM_DIV(300))
`define SPM_DIV_600      13'(`SPM_DIV(600))
`define SPM_DIV_1200     13'(`SPM_DIV(1200))
`define SPM_DIV_2400     13'(`SPM_DIV(2400))
`define SPM_DIV_4800     13'(`SPM_DIV(4800))
`define SPM_DIV_9600     13'(`SPM_DIV(9600))
`define SPM_DIV_19200    13'(`SPM_DIV(19200))

`endif

// ==== core/spm_pkg.sv ====
// Types shared by the serial merge block
`default_nettype none
package spm_pkg;

    // ------------------------------------------------------------------------
    // Frame settings common to both ports
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       loop_dis;
        logic       seven;
        logic       par_odd;
        logic       par_en;
        logic [2:0] baud;
    } spm_cfg_t;

    // Receive valid and error flags
    typedef struct packed {
        logic overrun;
        logic par_err;
        logic frame_err;
        logic valid;
    } spm_rxst_t;

    // Serial engine states, Gray along start, data, parity, stop
    typedef enum logic [2:0] {
        SPM_IDLE  = 3'b000,
        SPM_START = 3'b001,
        SPM_DATA  = 3'b011,
        SPM_PAR   = 3'b010,
        SPM_STOP  = 3'b110
    } spm_state_t;

endpackage : spm_pkg
`default_nettype wire

// ==== bench/spm_serial_merge_checker.sv ====
// Port-level assertions for the dual-port serial merge block
`timescale 1ns/1ps
`default_nettype none
`include "spm_cfg.svh"

module spm_serial_merge_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rs232_rx,
    input wire logic        loop_rx,
    input wire logic        rs232_tx,
    input wire logic        loop_tx
);
    // Shortest bit at the top rate; longest low run is start plus nine zero bits at 300
    localparam int BIT_MIN = 16 * (`SPM_DIV_19200 + 1);
    localparam int LOW_MAX = 10 * 16 * (`SPM_DIV_300 + 1);
    logic [20:0] low_cnt;
    logic [11:0] hold_cnt;
    logic        tx_q;
    logic        rd_dp;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Run lengths on the line; hold_cnt starts saturated so the first edge passes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt  <= 21'h0;
            hold_cnt <= 12'hfff;
            tx_q     <= 1'b1;
            rd_dp    <= 1'b0;
        end else begin
            low_cnt  <= rs232_tx ? 21'h0 : low_cnt + 21'h1;
            hold_cnt <= (rs232_tx != tx_q) ? 12'h0 : hold_cnt + {11'h0, hold_cnt != 12'hfff};
            tx_q     <= rs232_tx;
            rd_dp    <= hsel && hready && htrans[1] && !hwrite;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_rd(logic [11:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr == a;
    endsequence

    chk_tx_mirror: assert property (rs232_tx == loop_tx)
        else $error("transmit outputs differ");
    chk_bit_width: assert property ($changed(rs232_tx) |-> hold_cnt >= 12'(BIT_MIN - 1))
        else $error("transmit bit shorter than the fastest rate");
    chk_low_bound: assert property (low_cnt <= 21'(LOW_MAX))
        else $error("transmit line low longer than any frame allows");
    chk_ready_high: assert property (hreadyout)
        else $error("slave inserted a wait state");
    chk_resp_okay: assert property (!hresp)
        else $error("slave answered with an error");
    chk_rdata_idle: assert property (!rd_dp |-> hrdata == 32'h0)
        else $error("read data driven outside a read data phase");
    chk_addr_range: assert property (s_rd(`SPM_OFF_ADDR) |=> hrdata <= 32'h63)
        else $error("unit address above 99");
    chk_status_high: assert property (s_rd(`SPM_OFF_STATUS) |=> hrdata[31:5] == 27'h0)
        else $error("unused status bits set");
    chk_unmapped_rd: assert property (s_rd(12'h020) |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
endmodule : spm_serial_merge_checker

bind spm_serial_merge spm_serial_merge_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rs232_rx(rs232_rx), .loop_rx(loop_rx),
    .rs232_tx(rs232_tx), .loop_tx(loop_tx)
);
`default_nettype wire

// ==== bench/spm_host_model.sv ====
// Host serial port model: sends on either input line, decodes the mirrored output
`timescale 1ns/1ps
`default_nettype none

module spm_host_model #(
    parameter int BIT = 1296
) (
    input wire logic hclk,
    input wire logic rs232_tx,
    output var logic rs232_line,
    output var logic loop_line
);
    logic [7:0] rx_last;
    int         rx_count;

    // Both lines idle at mark so the other port can still be heard
    initial begin
        rs232_line = 1'b1;
        loop_line  = 1'b1;
    end

    // ------------------------------------------------------------------
    // Sender: only one line carries a frame at a time, never both
    // ------------------------------------------------------------------
    task automatic send(input logic on_loop, input logic [7:0] d, input int nb,
                        input logic pen, input logic podd, input logic bad);
        logic [10:0] fr;
        int          n;
        fr = 11'h7ff;
        fr[0] = 1'b0;
        for (n = 0; n < nb; n++) fr[n + 1] = d[n];
        n = nb + 1;
        if (pen) begin
            fr[n] = ^(d & 8'((1 << nb) - 1)) ^ podd ^ bad;
            n++;
        end
        for (int i = 0; i <= n; i++) begin
            if (on_loop) loop_line <= fr[i];
            else rs232_line <= fr[i];
            repeat (BIT) @(posedge hclk);
        end
    endtask : send

    // Holding the loop at space stands for an unpowered current loop
    task automatic set_loop(input logic lvl);
        loop_line <= lvl;
    endtask : set_loop

    // Receiver for 8N1 frames, sampled at bit centres
    initial begin
        logic [7:0] v;
        rx_count = 0;
        forever begin
            @(negedge rs232_tx);
            repeat (BIT / 2) @(posedge hclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge hclk);
                v[i] = rs232_tx;
            end
            repeat (BIT) @(posedge hclk);
            if (rs232_tx === 1'b1) begin
                rx_last = v;
                rx_count++;
            end
        end
    end
endmodule : spm_host_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Register and serial scenarios for the dual-port serial merge block
`timescale 1ns/1ps
`default_nettype none
`include "spm_cfg.svh"

module testbench;
    localparam int BIT = 16 * (`SPM_DIV_19200 + 1);
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  [31:0] hrdata;
    wire         hready;
    wire         hresp;
    wire         rs232_rx;
    wire         loop_rx;
    wire         rs232_tx;
    wire         loop_tx;
    int          err_count = 0;
    int          total_checks = 0;
    logic [31:0] aw [3] = '{32'h63, 32'h64, 32'h2a};
    logic [31:0] ae [3] = '{32'h63, 32'h63, 32'h2a};

    spm_serial_merge dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .rs232_rx(rs232_rx), .loop_rx(loop_rx),
        .rs232_tx(rs232_tx), .loop_tx(loop_tx)
    );
    spm_host_model #(.BIT(BIT)) host (
        .hclk(hclk), .rs232_tx(rs232_tx), .rs232_line(rs232_rx), .loop_line(loop_rx)
    );

    always #20 hclk = ~hclk;

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One single word transfer; address held until ready, data taken at the second edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        check(name, r, exp);
    endtask : rd_chk

    // Status, character, then status cleared by the character read
    task automatic rx_check(input logic [7:0] d, input logic [1:0] e);
        rd_chk("rx status", `SPM_OFF_STATUS, {29'h0, e, 1'b1});
        rd_chk("rx data", `SPM_OFF_RXDATA, {24'h0, d});
        rd_chk("status cleared", `SPM_OFF_STATUS, 32'h0);
    endtask : rx_check

    task automatic wrap_up;
        if (err_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Watchdog sized above the five frames plus register traffic
    initial begin
        repeat (100000) @(posedge hclk);
        err_count++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        hclk    = 1'b0;
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 12'h000;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'b010;
        hwdata  = 32'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("ctrl reset", `SPM_OFF_CTRL, `SPM_CTRL_RESET);
        rd_chk("status reset", `SPM_OFF_STATUS, 32'h0);
        rd_chk("addr reset", `SPM_OFF_ADDR, 32'(`SPM_ADDR_RESET));
        wr(12'h020, 32'hffffffff);
        rd_chk("unmapped", 12'h020, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(`SPM_OFF_ADDR, aw[i]);
            rd_chk("unit addr", `SPM_OFF_ADDR, ae[i]);
        end
        // 8 bits even parity on the RS-232 line, loop idle at mark
        wr(`SPM_OFF_CTRL, 32'h0e);
        rd_chk("ctrl", `SPM_OFF_CTRL, 32'h0e);
        host.send(1'b0, 8'h41, 8, 1'b1, 1'b0, 1'b0);
        rx_check(8'h41, 2'b00);
        // 7 bits odd parity on the loop, then a wrong parity bit
        wr(`SPM_OFF_CTRL, 32'h3e);
        host.send(1'b1, 8'h5a, 7, 1'b1, 1'b1, 1'b0);
        rx_check(8'h5a, 2'b00);
        host.send(1'b1, 8'h33, 7, 1'b1, 1'b1, 1'b1);
        rx_check(8'h33, 2'b10);
        // Loop disabled while the loop sits at space; send and receive overlap
        wr(`SPM_OFF_CTRL, 32'h47);
        host.set_loop(1'b0);
        fork
            host.send(1'b0, 8'h3c, 8, 1'b0, 1'b0, 1'b0);
            begin
                wr(`SPM_OFF_TXDATA, 32'h6b);
                rd_chk("tx busy", `SPM_OFF_STATUS, 32'h10);
            end
        join
        repeat (BIT) @(posedge hclk);
        rx_check(8'h3c, 2'b00);
        check("host char", {24'h0, host.rx_last}, 32'h6b);
        check("host count", 32'(host.rx_count), 32'h1);
        // Enabling the loop at space pulls the merged input low: framing error
        wr(`SPM_OFF_CTRL, 32'h06);
        repeat (11 * BIT) @(posedge hclk);
        host.set_loop(1'b1);
        repeat (BIT) @(posedge hclk);
        rx_check(8'h00, 2'b01);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
